/* File: design/ctm_defs.vh */
// Constants for the compact 10-bit timer: offsets, fields, reset values
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH
// Register offsets on the plain register port
`define CTM_OFS_CTRL0 3'h0
`define CTM_OFS_CTRL1 3'h1
`define CTM_OFS_CNTL 3'h2
`define CTM_OFS_CNTH 3'h3
`define CTM_OFS_DUTYL 3'h4
`define CTM_OFS_DUTYH 3'h5
`define CTM_OFS_FLAGS 3'h6
// Control 0 field positions
`define CTM_C0_PAUSE 7
`define CTM_C0_CLK_HI 6
`define CTM_C0_CLK_LO 4
`define CTM_C0_ON 3
`define CTM_C0_PER_HI 2
`define CTM_C0_PER_LO 0
// Control 1 field positions
`define CTM_C1_MODE_HI 7
`define CTM_C1_MODE_LO 6
`define CTM_C1_ACT_HI 5
`define CTM_C1_ACT_LO 4
`define CTM_C1_OC 3
`define CTM_C1_POL 2
`define CTM_C1_DPX 1
`define CTM_C1_CCLR 0
// Reset values
`define CTM_RST_CTRL 8'h00
`define CTM_RST_DUTY 10'h000
// Mode codes
`define CTM_MODE_CMP 2'h0
`define CTM_MODE_PWM 2'h2
`define CTM_MODE_TMR 2'h3
// Pin action codes
`define CTM_ACT_NONE 2'h0
`define CTM_ACT_LOW 2'h1
`define CTM_ACT_HIGH 2'h2
`define CTM_ACT_TGL 2'h3
// Clock select codes
`define CTM_CK_SYS4 3'h0
`define CTM_CK_SYS 3'h1
`define CTM_CK_H16 3'h2
`define CTM_CK_H64 3'h3
`define CTM_CK_SUB0 3'h4
`define CTM_CK_SUB1 3'h5
`define CTM_CK_EXTR 3'h6
`define CTM_CK_EXTF 3'h7
// Divider ratios
`define CTM_DIV_SYS 4
`define CTM_DIV_H16 16
`define CTM_DIV_H64 64
// Counter top value
`define CTM_CNT_MAX 10'h3FF
`endif

/* File: design/ctm_clk_sel.v */
// Count clock selection: dividers, edge detector and source multiplexer
`timescale 1ns/1ps
`include "ctm_defs.vh"
module ctm_clk_sel (
    mclk,
    rst_n,
    high_clk_en,
    sub_clk_en,
    ext_pin,
    sel,
    tick
);
    input wire mclk;
    input wire rst_n;
    input wire high_clk_en; // High internal clock rate, as enable pulse
    input wire sub_clk_en; // Subsidiary clock rate, as enable pulse
    input wire ext_pin; // External count clock pin, synchronous
    input wire [2:0] sel; // Clock select field
    output reg tick; // One-cycle count enable

    reg [1:0] sys_div_ff; // Divide by four of the system clock
    reg [5:0] h_div_ff; // Divider on high clock enables
    reg ext_prev_ff; // Last sample of the external pin
    reg nxt_tick;

    // Dividers run free; a pulse on wrap gives the slower rate
    always @(posedge mclk) begin
        if (!rst_n) begin
            sys_div_ff <= 2'h0;
            h_div_ff <= 6'h00;
            ext_prev_ff <= 1'b0;
            tick <= 1'b0;
        end else begin
            sys_div_ff <= sys_div_ff + 2'h1;
            if (high_clk_en) begin
                h_div_ff <= h_div_ff + 6'h01;
            end
            ext_prev_ff <= ext_pin;
            tick <= nxt_tick;
        end
    end

    // Source multiplexer
    always @* begin
        case (sel)
            `CTM_CK_SYS4: nxt_tick = (sys_div_ff == 2'h3);
            `CTM_CK_SYS: nxt_tick = 1'b1;
            `CTM_CK_H16: nxt_tick = high_clk_en && (h_div_ff[3:0] == 4'hF);
            `CTM_CK_H64: nxt_tick = high_clk_en && (h_div_ff == 6'h3F);
            `CTM_CK_SUB0: nxt_tick = sub_clk_en;
            `CTM_CK_SUB1: nxt_tick = sub_clk_en;
            // External edges, rising or falling
            `CTM_CK_EXTR: nxt_tick = ext_pin && !ext_prev_ff;
            `CTM_CK_EXTF: nxt_tick = !ext_pin && ext_prev_ff;
            default: nxt_tick = 1'b0;
        endcase
    end
endmodule // ctm_clk_sel

/* File: design/ctm_out_pin.v */
// Output pin logic for compare-match and edge-aligned PWM modes
`timescale 1ns/1ps
`include "ctm_defs.vh"
module ctm_out_pin (
    mclk,
    rst_n,
    mode,
    action,
    init_lvl,
    invert,
    restart,
    duty_hit,
    period_hit,
    pin
);
    input wire mclk;
    input wire rst_n;
    input wire [1:0] mode; // Operating mode
    input wire [1:0] action; // Pin action field
    input wire init_lvl; // Initial level or active level
    input wire invert; // Output polarity invert
    input wire restart; // Module switched on: back to initial, inactive in PWM
    input wire duty_hit; // Duty point reached this cycle
    input wire period_hit; // Period end reached this cycle
    output reg pin; // Timer output pin

    reg state_ff; // Internal level before polarity
    reg nxt_state;

    // Next internal level by mode
    always @* begin
        nxt_state = state_ff;
        if (restart) begin
            // Back to the initial level on switch-on; to the inactive level in PWM mode
            nxt_state = (mode == `CTM_MODE_PWM) ? !init_lvl : init_lvl;
        end else if (mode == `CTM_MODE_CMP) begin
            if (duty_hit) begin
                case (action)
                    `CTM_ACT_LOW: nxt_state = 1'b0;
                    `CTM_ACT_HIGH: nxt_state = 1'b1;
                    `CTM_ACT_TGL: nxt_state = !state_ff;
                    default: nxt_state = state_ff;
                endcase
            end
        end else if (mode == `CTM_MODE_PWM) begin
            // Action high: active from period start until duty point; none holds inactive, low holds active
            case (action)
                `CTM_ACT_NONE: nxt_state = !init_lvl;
                `CTM_ACT_LOW: nxt_state = init_lvl;
                `CTM_ACT_HIGH: begin
                    if (period_hit) begin
                        nxt_state = init_lvl;
                    end else if (duty_hit) begin
                        nxt_state = !init_lvl;
                    end
                end
                default: nxt_state = state_ff;
            endcase
        end
    end

    // Register the level; polarity applied on the way out
    always @(posedge mclk) begin
        if (!rst_n) begin
            state_ff <= 1'b0;
            pin <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            // Timer mode forces the pin low, ignoring the polarity bit
            pin <= (mode == `CTM_MODE_TMR) ? 1'b0 : (nxt_state ^ invert);
        end
    end
endmodule // ctm_out_pin

/* File: design/ctm_top.v */
// Compact 10-bit timer: counter, comparators, byte buffer and registers
// What this block does
// - Ten-bit up-counter advanced by count clock
// - Period comparator checks top three counter bits
// - Duty comparator checks all ten counter bits
// - Software clears the counter only by switch-on edge
// - Overflow or selected match clears the counter
// - Two interrupts, one per comparator match
// - Three-bit field selects the count clock
// - External pin counts rising or falling edges
// - Compare mode drives pin high, low, toggle
// - Edge-aligned PWM, duty or period adjustable
// - Compare, timer/counter and PWM modes exist
// - Buffer moves on high byte reads and duty low byte writes
// - Duty low byte write lands in buffer
// - High byte write also loads low from buffer
// - High byte read copies low byte into buffer
// - Low byte reads return the buffer
// - Clock field decodes eight codes, codes 4 and 5 both the subsidiary clock
// - Period code counts 128 clocks, zero means 1024
// - Mode field: 00 compare, 10 PWM, 11 timer
// - Pin action: none, low, high, toggle
`timescale 1ns/1ps
`include "ctm_defs.vh"
module ctm_top #(
    parameter CNT_W = 10
) (
    mclk,
    rst_n,
    high_clk_en,
    sub_clk_en,
    external_count_clock_pin,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    timer_output_pin,
    duty_match_irq,
    period_match_irq
);
    input wire mclk;
    input wire rst_n;
    input wire high_clk_en; // High internal clock as enable pulses
    input wire sub_clk_en; // Subsidiary clock as enable pulses
    input wire external_count_clock_pin; // Event input
    input wire [2:0] reg_addr; // Register offset
    input wire [7:0] reg_wdata; // Write data
    input wire reg_wr; // Write strobe
    input wire reg_rd; // Read strobe
    output reg [7:0] reg_rdata; // Read data, cycle after strobe
    output wire timer_output_pin; // Timer output, from a flip-flop
    output reg duty_match_irq; // Duty comparator match pulse
    output reg period_match_irq; // Period comparator match pulse

    // Control registers and derived fields
    reg [7:0] ctrl0_ff; // Pause, clock select, on, period code
    reg [7:0] ctrl1_ff; // Mode, action, level, polarity, pwm, clear sel
    reg [CNT_W-1:0] cnt_ff; // Main counter
    reg [CNT_W-1:0] duty_compare_value; // Duty compare register
    reg [7:0] share_buf_ff; // Shared low byte buffer
    reg on_prev_ff; // Last value of the on control
    reg [1:0] sticky_ff; // Event record: bit0 duty, bit1 period
    reg [CNT_W-1:0] nxt_cnt;
    reg [7:0] nxt_rdata;
    reg [1:0] nxt_sticky;

    wire tick; // Count enable from the clock selector
    wire module_on_control = ctrl0_ff[`CTM_C0_ON];
    wire pause = ctrl0_ff[`CTM_C0_PAUSE];
    wire [2:0] count_clock_select_field = ctrl0_ff[`CTM_C0_CLK_HI:`CTM_C0_CLK_LO];
    wire [2:0] period_compare_value = ctrl0_ff[`CTM_C0_PER_HI:`CTM_C0_PER_LO];
    wire [1:0] mode_select_bits = ctrl1_ff[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
    wire [1:0] pin_action_bits = ctrl1_ff[`CTM_C1_ACT_HI:`CTM_C1_ACT_LO];
    wire dpx = ctrl1_ff[`CTM_C1_DPX];
    wire clear_on_duty = ctrl1_ff[`CTM_C1_CCLR];

    // Switch-on edge: the only software path that touches the counter
    wire switch_on = module_on_control && !on_prev_ff;
    wire running = module_on_control && !pause && tick;

    // Matches are taken on the counter's value as it is reached
    wire [CNT_W-1:0] cnt_inc = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    wire overflow = running && (cnt_ff == `CTM_CNT_MAX);
    // Period compare on top three bits; code zero waits for overflow
    wire period_hit = running && ((period_compare_value == 3'h0) ?
        (cnt_ff == `CTM_CNT_MAX) :
        (cnt_inc[CNT_W-1:CNT_W-3] == period_compare_value &&
         cnt_inc[CNT_W-4:0] == {(CNT_W-3){1'b0}}));
    wire duty_hit = running &&
        (cnt_inc == duty_compare_value);
    wire clear_hit = clear_on_duty ? duty_hit : period_hit;
    // PWM roles swap with the duty/period control bit
    wire pwm_period = dpx ? duty_hit : period_hit;
    wire pwm_duty = dpx ? period_hit : duty_hit;

    // Count clock selection
    ctm_clk_sel u_clk_sel (
        .mclk(mclk),
        .rst_n(rst_n),
        .high_clk_en(high_clk_en),
        .sub_clk_en(sub_clk_en),
        .ext_pin(external_count_clock_pin),
        .sel(count_clock_select_field),
        .tick(tick)
    );

    // Output pin; compare mode uses the duty comparator alone
    ctm_out_pin u_out_pin (
        .mclk(mclk),
        .rst_n(rst_n),
        .mode(mode_select_bits),
        .action(pin_action_bits),
        .init_lvl(ctrl1_ff[`CTM_C1_OC]),
        .invert(ctrl1_ff[`CTM_C1_POL]),
        .restart(switch_on),
        .duty_hit((mode_select_bits == `CTM_MODE_PWM) ? pwm_duty : duty_hit),
        .period_hit(pwm_period),
        .pin(timer_output_pin)
    );

    // Counter next value
    always @* begin
        nxt_cnt = cnt_ff;
        if (switch_on) begin
            nxt_cnt = {CNT_W{1'b0}};
        end else if (overflow || (running && clear_hit)) begin
            // Wrap or cleared by the chosen comparator
            nxt_cnt = {CNT_W{1'b0}};
        end else if (running) begin
            nxt_cnt = cnt_inc;
        end
    end

    // Read multiplexer; low bytes come from the buffer
    always @* begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            `CTM_OFS_CTRL0: nxt_rdata = ctrl0_ff;
            `CTM_OFS_CTRL1: nxt_rdata = ctrl1_ff;
            `CTM_OFS_CNTL: nxt_rdata = share_buf_ff;
            `CTM_OFS_CNTH: nxt_rdata = {6'h00, cnt_ff[CNT_W-1:8]};
            `CTM_OFS_DUTYL: nxt_rdata = share_buf_ff;
            `CTM_OFS_DUTYH: nxt_rdata = {6'h00, duty_compare_value[CNT_W-1:8]};
            `CTM_OFS_FLAGS: nxt_rdata = {6'h00, sticky_ff};
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Event record: set wins over a write-one-to-clear in the same cycle
    always @* begin
        nxt_sticky = sticky_ff;
        if (reg_wr && reg_addr == `CTM_OFS_FLAGS) begin
            nxt_sticky = sticky_ff & ~reg_wdata[1:0];
        end
        nxt_sticky = nxt_sticky | {period_hit, duty_hit};
    end

    // Registers, buffer transfers and counter
    always @(posedge mclk) begin
        if (!rst_n) begin
            ctrl0_ff <= `CTM_RST_CTRL;
            ctrl1_ff <= `CTM_RST_CTRL;
            cnt_ff <= {CNT_W{1'b0}};
            duty_compare_value <= `CTM_RST_DUTY;
            share_buf_ff <= 8'h00;
            on_prev_ff <= 1'b0;
            sticky_ff <= 2'h0;
            reg_rdata <= 8'h00;
            duty_match_irq <= 1'b0;
            period_match_irq <= 1'b0;
        end else begin
            on_prev_ff <= module_on_control;
            cnt_ff <= nxt_cnt;
            sticky_ff <= nxt_sticky;
            // One interrupt pulse per comparator match
            duty_match_irq <= duty_hit;
            period_match_irq <= period_hit;
            if (reg_rd) begin
                reg_rdata <= nxt_rdata;
                // High byte read latches live low byte
                if (reg_addr == `CTM_OFS_CNTH) begin
                    share_buf_ff <= cnt_ff[7:0];
                end else if (reg_addr == `CTM_OFS_DUTYH) begin
                    share_buf_ff <= duty_compare_value[7:0];
                end
            end else begin
                reg_rdata <= 8'h00;
            end
            if (reg_wr) begin
                case (reg_addr)
                    `CTM_OFS_CTRL0: ctrl0_ff <= reg_wdata;
                    `CTM_OFS_CTRL1: ctrl1_ff <= reg_wdata;
                    // Low byte write goes only to the buffer
                    `CTM_OFS_DUTYL: share_buf_ff <= reg_wdata;
                    `CTM_OFS_DUTYH: begin
                        // High direct, low from buffer
                        duty_compare_value <= {reg_wdata[1:0], share_buf_ff};
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule // ctm_top

/* File: bench/ctm_src.sv */
// Far-side model: internal clock enables and external event source
`timescale 1ns/1ps
module ctm_src (
    input wire mclk,
    input wire run, // Event pin moves only while run is high
    output reg hi_en, // High clock enable, every second cycle
    output reg sub_en, // Subsidiary enable, every eighth cycle
    output reg ext_pin // Event pin, one full period per 8 cycles
);
    reg [2:0] ph_ff; // Free-running phase
    initial begin
        ph_ff = 3'h0;
        ext_pin = 1'b0;
    end
    // Pulses change just after the edge, like real synchronous sources
    always @(posedge mclk) begin
        ph_ff <= ph_ff + 3'h1;
        hi_en <= ph_ff[0];
        sub_en <= (ph_ff == 3'h7);
        // Stands still between bursts so stale edges never count
        if (run && ph_ff[1:0] == 2'h3) begin
            ext_pin <= ~ext_pin;
        end
    end
endmodule // ctm_src

/* File: bench/ctm_top_properties.sv */
// Port-level assertions for the compact timer and their bind
`timescale 1ns/1ps
module ctm_top_props #(
    parameter CNT_W = 10
) (
    input wire mclk,
    input wire rst_n,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire timer_output_pin,
    input wire duty_match_irq,
    input wire period_match_irq
);
    reg [7:0] c0_ff, c1_ff; // Control register mirrors
    reg [7:0] buf_ff; // Low-byte buffer mirror
    reg [CNT_W-1:0] duty_ff; // Duty compare mirror
    reg bok_ff; // Buffer mirror valid; a counter high byte read spoils it
    reg [3:0] quiet_ff; // Cycles since a control write, saturating
    wire [1:0] duty_hi = duty_ff[9:8];
    // Mirror what software wrote; the counter itself is not visible
    always @(posedge mclk) begin
        if (!rst_n) begin
            c0_ff <= 8'h00;
            c1_ff <= 8'h00;
            duty_ff <= 10'h000;
            bok_ff <= 1'b0;
            quiet_ff <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == 3'h0) c0_ff <= reg_wdata;
            if (reg_wr && reg_addr == 3'h1) c1_ff <= reg_wdata;
            if (reg_wr && reg_addr == 3'h4) begin
                buf_ff <= reg_wdata;
                bok_ff <= 1'b1;
            end
            if (reg_wr && reg_addr == 3'h5) begin
                duty_ff <= {reg_wdata[1:0], buf_ff};
            end
            if (reg_rd && reg_addr == 3'h5) begin
                buf_ff <= duty_ff[7:0];
                bok_ff <= 1'b1;
            end
            if (reg_rd && reg_addr == 3'h3) bok_ff <= 1'b0;
            if (reg_wr && reg_addr < 3'h2) quiet_ff <= 4'h0;
            else if (quiet_ff != 4'hF) quiet_ff <= quiet_ff + 4'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read");
    reset_quiet_a: assert property ($rose(rst_n) |-> reg_rdata == 8'h00
        && !timer_output_pin && !duty_match_irq && !period_match_irq)
        else $error("outputs not quiet after reset");
    ctrl0_read_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == 3'h0 |-> reg_rdata == $past(c0_ff))
        else $error("control 0 read back wrong");
    ctrl1_read_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == 3'h1 |-> reg_rdata == $past(c1_ff))
        else $error("control 1 read back wrong");
    duty_high_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == 3'h5 |-> reg_rdata[7:2] == 6'h00 &&
        reg_rdata[1:0] == $past(duty_hi))
        else $error("duty high byte wrong");
    low_buffer_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == 3'h4 && $past(bok_ff) |->
        reg_rdata == $past(buf_ff))
        else $error("low byte read not from buffer");
    unmapped_read_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == 3'h7 |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    off_quiet_a: assert property (!c0_ff[3] && quiet_ff > 4'h3 |->
        !duty_match_irq && !period_match_irq)
        else $error("match pulse while switched off");
    timer_pin_a: assert property (c1_ff[7:6] == 2'h3 &&
        quiet_ff > 4'h3 |-> !timer_output_pin)
        else $error("pin active in timer mode");
    hold_pin_a: assert property (c1_ff[7:4] == 4'h0 &&
        quiet_ff > 4'h3 |-> $stable(timer_output_pin))
        else $error("pin moved with no action set");
endmodule // ctm_top_props
bind ctm_top ctm_top_props #(.CNT_W(CNT_W)) chk (.mclk(mclk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_output_pin(timer_output_pin),
    .duty_match_irq(duty_match_irq),
    .period_match_irq(period_match_irq));

/* File: bench/test_ctm_top.sv */
// Self-checking bench for the compact timer
`timescale 1ns/1ps
module test_ctm_top;
    reg mclk, rst_n, reg_wr, reg_rd, run;
    reg [2:0] reg_addr;
    reg [7:0] reg_wdata, rd_v, hi_v, v0, v1;
    reg [31:0] rng; // Random state
    reg [9:0] d; // Duty value under test
    wire [7:0] reg_rdata;
    wire hi_en, sub_en, ext_pin, pin, dirq, pirq;
    integer bad_count, total_checks, i, k, n;
    time t1, t2; // Moments of two match pulses
    ctm_top #(.CNT_W(10)) dut (.mclk(mclk), .rst_n(rst_n),
        .high_clk_en(hi_en), .sub_clk_en(sub_en),
        .external_count_clock_pin(ext_pin), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .timer_output_pin(pin),
        .duty_match_irq(dirq), .period_match_irq(pirq));
    ctm_src src (.mclk(mclk), .run(run), .hi_en(hi_en),
        .sub_en(sub_en), .ext_pin(ext_pin));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Xorshift step for repeatable random values
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // Expected counts in 256 cycles for each clock code
    function integer rate_exp(input integer c);
        begin
            case (c)
                0: rate_exp = 64;
                1: rate_exp = 256;
                2: rate_exp = 8;
                3: rate_exp = 2;
                default: rate_exp = 32;
            endcase
        end
    endfunction
    task check(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task summarize;
        begin
            if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // Bus tasks start and end just after a rising edge
    task wr(input [2:0] a, input [7:0] v);
        begin
            reg_addr <= a;
            reg_wdata <= v;
            reg_wr <= 1'b1;
            @(posedge mclk);
            reg_wr <= 1'b0;
            // Idle edge: a following write never re-raises in this step
            @(posedge mclk);
        end
    endtask
    task rd(input [2:0] a, output [7:0] v);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge mclk);
            reg_rd <= 1'b0;
            #1 v = reg_rdata;
            @(posedge mclk);
        end
    endtask
    task wt(input integer c);
        repeat (c) @(posedge mclk);
    endtask
    // Wait, bounded, for a match pulse and note when it came
    task wirq(input sel, output time t);
        integer c;
        begin
            c = 0;
            @(posedge mclk);
            #1;
            while ((sel ? pirq : dirq) !== 1'b1 && c < 3000) begin
                @(posedge mclk);
                #1 c = c + 1;
            end
            t = $time;
            if (c >= 3000) check(c, 0);
            @(posedge mclk);
        end
    endtask
    initial begin
        #(20 * 60000);
        bad_count = bad_count + 1;
        summarize;
    end
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        run = 1'b0;
        bad_count = 0;
        total_checks = 0;
        rng = 32'hbff9;
        wt(8);
        rst_n <= 1'b1;
        @(posedge mclk);
        // Reset values, and an unmapped write that must vanish
        wr(3'h7, 8'hFF);
        for (i = 0; i < 5; i = i + 1) begin
            rd(i == 2 ? 3'h5 : i == 3 ? 3'h4 : i == 4 ? 3'h7 : i, rd_v);
            check(rd_v, 0);
        end
        // Random register traffic, timer kept off
        for (i = 0; i < 6; i = i + 1) begin
            rng = xs(rng);
            v0 = rng[7:0] & 8'hF7;
            v1 = rng[15:8];
            d = rng[25:16];
            wr(3'h0, v0);
            wr(3'h1, v1);
            wr(3'h4, d[7:0]);
            wr(3'h5, {6'h00, d[9:8]});
            wr(3'h4, ~d[7:0]);
            rd(3'h0, rd_v);
            check(rd_v, v0);
            rd(3'h1, rd_v);
            check(rd_v, v1);
            rd(3'h5, rd_v);
            check(rd_v, d[9:8]);
            rd(3'h4, rd_v);
            check(rd_v, d[7:0]);
        end
        // Every clock source in timer mode; switch-on clears the count
        wr(3'h1, 8'hC0);
        run <= 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            wr(3'h0, {1'b0, i[2:0], 4'h0});
            wr(3'h0, {1'b0, i[2:0], 4'h8});
            wt(256);
            wr(3'h0, {1'b1, i[2:0], 4'h8});
            rd(3'h3, hi_v);
            rd(3'h2, rd_v);
            n = {hi_v[1:0], rd_v};
            n = n - rate_exp(i);
            check(n > -4 && n < 4, 1);
        end
        run <= 1'b0;
        // Period comparator spacing, code zero being full overflow
        wr(3'h1, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            k = (i == 0) ? 0 : 2 * i - 1;
            wr(3'h0, {5'h02, k[2:0]});
            wr(3'h0, {5'h03, k[2:0]});
            wirq(1'b1, t1);
            wirq(1'b1, t2);
            n = (t2 - t1) / 20;
            check(n, k == 0 ? 1024 : 128 * k);
        end
        // Every pin action on duty matches, counter cleared on duty
        wr(3'h4, 8'h32);
        wr(3'h5, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            wr(3'h1, {2'h0, i[1:0], 4'h1});
            wr(3'h0, 8'h10);
            wr(3'h0, 8'h18);
            wirq(1'b0, t1);
            wt(2);
            check(pin, i[1]);
            wirq(1'b0, t2);
            wt(2);
            check(pin, i == 3 ? 0 : i[1]);
            n = (t2 - t1) / 20;
            check(n, 50);
        end
        // Edge-aligned PWM, duty 32 of 128, both polarities; then roles
        // swapped, the duty register setting a period of 320 clocks
        for (i = 0; i < 3; i = i + 1) begin
            wr(3'h4, i == 2 ? 8'h40 : 8'h20);
            wr(3'h5, i == 2 ? 8'h01 : 8'h00);
            wr(3'h1, {5'h15, i[0], i[1], i[1]});
            wr(3'h0, 8'h11);
            wr(3'h0, 8'h19);
            wt(300);
            n = 0;
            for (k = 0; k < 1280; k = k + 1) begin
                @(posedge mclk);
                #1 n = n + pin;
            end
            @(posedge mclk);
            k = i[1] ? 512 : i[0] ? 960 : 320;
            check(n, k);
        end
        // Event record: both comparators matched above; write one clears
        wr(3'h0, 8'h11);
        rd(3'h6, rd_v);
        check(rd_v, 8'h03);
        wr(3'h6, 8'h03);
        rd(3'h6, rd_v);
        check(rd_v, 8'h00);
        summarize;
    end
endmodule // test_ctm_top
